/* File: logic/sbst_tap.sv */
// Test access port of the burst memory: instruction, bypass, identification and boundary paths.
`timescale 1ns/1ps
// Notes on behaviour
// - Code 000: capture ring, boundary path, outputs off.
// - Code 001: load identification word, memory untouched.
// - Code 010: capture ring, boundary path, outputs off.
// - Code 100: capture ring, boundary path, no preload.
// - Code 111: one-bit bypass path, memory untouched.
// - Identification is 32 bits, bit 0 one.
// - Bits 11:1 carry the maker code.
// - Bits 31:28 carry the revision.
// - Bits 27:23 depth, bits 22:18 word width.
// - Bits 17:12 carry reserved device identifier.
// - Identification selected at reset and test-logic-reset.
// - Update-DR under sample acts like pause.
module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [3:0]  ID_REVISION = 4'h0,  // Revision field, neutral default.
  parameter logic [4:0]  ID_DEPTH    = 5'h00, // Depth field, neutral default.
  parameter logic [4:0]  ID_WIDTH    = 5'h00, // Width field, neutral default.
  parameter logic [5:0]  ID_DEVICE   = 6'h00, // Reserved device field.
  parameter logic [10:0] ID_MAKER    = 11'h2A5 // Maker code; value is arbitrary.
)
(
  input  wire logic                    CLK_IN,         // Memory-side clock, 10 MHz.
  input  wire logic                    RESET_IN,       // Synchronous reset, active high.
  input  wire logic                    TCK_IN,         // Test clock from the controller.
  input  wire logic                    TMS_IN,         // Test mode select.
  input  wire logic                    TDI_IN,         // Test data in.
  input  wire logic [SBST_BSR_LEN-1:0] RING_IN,        // Pin levels of the I/O ring, bit 0 first.
  output logic                         TDO_OUT,        // Test data out.
  output logic                         TDO_EN_OUT,     // High while test data out is driven.
  output logic                         OUTPUTS_OFF_OUT // High forces memory outputs off.
);

  // Reset carried into the test clock domain.
  logic rst_s1_r; // First synchroniser stage.
  logic rst_s2_r; // Second stage, used as the test domain reset.
  logic tck_rst;  // Test domain reset.

  // Two flops bring the reset across; the test clock may start after the reset edge.
  always_ff @(posedge TCK_IN)
  begin
    rst_s1_r <= RESET_IN;
    rst_s2_r <= rst_s1_r;
  end
  assign tck_rst = rst_s2_r;

  // Ring levels change on the fast memory clock, so they are resynchronised here.
  // A pin moving near capture may still read either way; software must hold it still.
  logic [SBST_BSR_LEN-1:0] ring_s1_r; // First stage.
  logic [SBST_BSR_LEN-1:0] ring_s2_r; // Second stage, read by capture.

  // Two-flop synchroniser for the ring.
  always_ff @(posedge TCK_IN)
  begin
    ring_s1_r <= RING_IN;
    ring_s2_r <= ring_s1_r;
  end

  // Controller sequencer.
  sbst_state_e state; // Present controller state.

  sbst_tap_fsm u_fsm (
    .tck_in    (TCK_IN),
    .rst_in    (tck_rst),
    .tms_in    (TMS_IN),
    .state_out (state)
  );

  // Instruction shifter and active instruction.
  logic [SBST_IR_LEN-1:0] ir_shift_r;   // Instruction shifter.
  logic [SBST_IR_LEN-1:0] ir_shift_nxt; // Its next value.
  logic [SBST_IR_LEN-1:0] ir_r;         // Active instruction.
  logic [SBST_IR_LEN-1:0] ir_nxt;       // Its next value.

  // Instruction path: capture fixed pattern, shift toward bit 0, commit on update.
  always_comb
  begin
    ir_shift_nxt = ir_shift_r;
    ir_nxt       = ir_r;
    case (state)
      SBST_TLR:   ir_nxt = SBST_IR_IDCODE;
      SBST_CAPIR: ir_shift_nxt = SBST_IR_CAPTURE;
      SBST_SHIR:  ir_shift_nxt = {TDI_IN, ir_shift_r[SBST_IR_LEN-1:1]};
      SBST_UPIR:  ir_nxt = ir_shift_r;
      default:    ir_nxt = ir_r;
    endcase
  end

  // Instruction registers; reset selects identification.
  always_ff @(posedge TCK_IN)
  begin
    if (tck_rst)
    begin
      ir_shift_r <= SBST_IR_CAPTURE;
      ir_r       <= SBST_IR_IDCODE;
    end
    else
    begin
      ir_shift_r <= ir_shift_nxt;
      ir_r       <= ir_nxt;
    end
  end

  // Identification word assembled from its fields.
  logic [SBST_ID_LEN-1:0] id_word; // Constant word loaded on capture.

  always_comb
  begin
    id_word = '0;
    id_word[SBST_ID_PRESENT_BIT]     = 1'b1;
    id_word[SBST_ID_MAKER_LSB +: 11] = ID_MAKER;
    id_word[SBST_ID_DEVICE_LSB +: 6] = ID_DEVICE;
    id_word[SBST_ID_WIDTH_LSB +: 5]  = ID_WIDTH;
    id_word[SBST_ID_DEPTH_LSB +: 5]  = ID_DEPTH;
    id_word[SBST_ID_REV_LSB +: 4]    = ID_REVISION;
  end

  // Data registers.
  logic [SBST_BSR_LEN-1:0] bsr_r;   // Boundary chain, bit 0 nearest test data out.
  logic [SBST_BSR_LEN-1:0] bsr_nxt; // Its next value.
  logic [SBST_ID_LEN-1:0]  id_r;    // Identification shifter.
  logic [SBST_ID_LEN-1:0]  id_nxt;  // Its next value.
  logic                    byp_r;   // Bypass bit.
  logic                    byp_nxt; // Its next value.
  logic                    sel_bsr; // Boundary chain in the path.
  logic                    sel_id;  // Identification in the path.

  // Reserved codes fall through to bypass, which keeps the chain length defined.
  assign sel_bsr = sbst_uses_bsr(ir_r);
  assign sel_id  = (ir_r == SBST_IR_IDCODE);

  // Data path: capture on Capture-DR, shift on Shift-DR; Update-DR loads nothing.
  always_comb
  begin
    bsr_nxt = bsr_r;
    id_nxt  = id_r;
    byp_nxt = byp_r;
    if (state == SBST_CAPDR)
    begin
      if (sel_bsr)
        bsr_nxt = ring_s2_r;
      else if (sel_id)
        id_nxt = id_word;
      else
        byp_nxt = SBST_BYPASS_CAPTURE;
    end
    else if (state == SBST_SHDR)
    begin
      if (sel_bsr)
        bsr_nxt = {TDI_IN, bsr_r[SBST_BSR_LEN-1:1]};
      else if (sel_id)
        id_nxt = {TDI_IN, id_r[SBST_ID_LEN-1:1]};
      else
        byp_nxt = TDI_IN;
    end
    // No preload stage exists, so Update-DR leaves every register as it is.
  end

  // Data registers clear on reset.
  always_ff @(posedge TCK_IN)
  begin
    if (tck_rst)
    begin
      bsr_r <= '0;
      id_r  <= '0;
      byp_r <= SBST_BYPASS_CAPTURE;
    end
    else
    begin
      bsr_r <= bsr_nxt;
      id_r  <= id_nxt;
      byp_r <= byp_nxt;
    end
  end

  // Output stage: updated on the falling test clock edge.
  logic tdo_nxt;    // Next test data out.
  logic tdo_en_nxt; // Next output enable.

  // Source follows the state; the pin is driven only while shifting.
  always_comb
  begin
    tdo_en_nxt = (state == SBST_SHIR) || (state == SBST_SHDR);
    if (state == SBST_SHIR)
      tdo_nxt = ir_shift_r[0];
    else if (state == SBST_SHDR)
      tdo_nxt = sel_bsr ? bsr_r[0] : (sel_id ? id_r[0] : byp_r);
    else
      tdo_nxt = 1'b0;
  end

  // Falling edge gives the controller half a cycle of settle before it samples.
  always_ff @(negedge TCK_IN)
  begin
    if (tck_rst)
    begin
      TDO_OUT    <= 1'b0;
      TDO_EN_OUT <= 1'b0;
    end
    else
    begin
      TDO_OUT    <= tdo_nxt;
      TDO_EN_OUT <= tdo_en_nxt;
    end
  end

  // Output-off request, registered in the test domain before crossing.
  logic off_r;   // Request held in the test domain.
  logic off_nxt; // Its next value.

  assign off_nxt = sbst_forces_off(ir_r);

  always_ff @(posedge TCK_IN)
  begin
    if (tck_rst)
      off_r <= SBST_OFF_RESET;
    else
      off_r <= off_nxt;
  end

  // Level crossing into the memory clock domain.
  logic off_s1_r; // First stage.
  logic off_s2_r; // Second stage, drives the pin control.

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      off_s1_r <= SBST_OFF_RESET;
      off_s2_r <= SBST_OFF_RESET;
    end
    else
    begin
      off_s1_r <= off_r;
      off_s2_r <= off_s1_r;
    end
  end
  assign OUTPUTS_OFF_OUT = off_s2_r;

  // Checks on the test clock domain, except the output-off crossing check on the memory clock.
  a_reset_idcode: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_TLR) |=> (ir_r == SBST_IR_IDCODE))
    else $error("Identification not selected after test-logic-reset.");
  a_id_capture: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_CAPDR && ir_r == SBST_IR_IDCODE) |=> (id_r == id_word))
    else $error("Identification word not captured.");
  a_id_fields: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_CAPDR && sel_id) |=> (id_r[0] == 1'b1 && id_r[11:1] == ID_MAKER && id_r[31:28] == ID_REVISION))
    else $error("Identification fields wrong after capture.");
  a_off_decode: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    $rose(ir_r == SBST_IR_EXTEST || ir_r == SBST_IR_SAMPLEZ) |=> off_r)
    else $error("Outputs not forced off for an output-off code.");
  a_sample_on: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (ir_r == SBST_IR_SAMPLE) [*2] |-> !off_r)
    else $error("Sample disturbed the memory outputs.");
  a_bsr_capture: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_CAPDR && ir_r == SBST_IR_SAMPLEZ) |=> (bsr_r == $past(ring_s2_r)))
    else $error("Ring not captured into boundary chain.");
  a_update_hold: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_UPDR) |=> $stable(bsr_r) && $stable(id_r) && $stable(byp_r))
    else $error("Update-DR altered a data register.");
  a_bypass_path: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_SHDR && ir_r == SBST_IR_BYPASS) |=> (byp_r == $past(TDI_IN)))
    else $error("Bypass bit did not follow test data in.");
  a_tms_reset: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    TMS_IN [*5] |=> (state == SBST_TLR))
    else $error("Five mode-select highs did not reach test-logic-reset.");
  a_chain_length: assert property (@(posedge TCK_IN) disable iff (tck_rst)
    (state == SBST_SHDR && sel_bsr) |=> (bsr_r[SBST_BSR_LEN-1] == $past(TDI_IN)))
    else $error("Boundary chain entry bit wrong.");
  a_off_cross: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $rose(off_r) |-> ##[1:3] OUTPUTS_OFF_OUT)
    else $error("Output-off request did not cross.");

  // Main scenarios.
  c_id_shift:  cover property (@(posedge TCK_IN) (state == SBST_SHDR && sel_id));
  c_bsr_shift: cover property (@(posedge TCK_IN) (state == SBST_SHDR && sel_bsr));
  c_ir_update: cover property (@(posedge TCK_IN) (state == SBST_UPIR));
  c_off_pin:   cover property (@(posedge CLK_IN) $rose(OUTPUTS_OFF_OUT));

endmodule // sbst_tap

/* File: logic/sbst_tap_fsm.sv */
// Sixteen-state test access controller sequencer clocked by the test clock.
`timescale 1ns/1ps
module sbst_tap_fsm
  import sbst_pkg::*;
(
  input  wire logic        tck_in,   // Test clock.
  input  wire logic        rst_in,   // Synchronous reset in the test clock domain.
  input  wire logic        tms_in,   // Mode select, sampled on the rising edge.
  output sbst_state_e      state_out // Present controller state.
);

  sbst_state_e state_r;   // Present state.
  sbst_state_e state_nxt; // Next state.

  // Next state follows the standard walk; mode select high walks toward reset.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SBST_TLR:   state_nxt = tms_in ? SBST_TLR   : SBST_RTI;
      SBST_RTI:   state_nxt = tms_in ? SBST_SELDR : SBST_RTI;
      SBST_SELDR: state_nxt = tms_in ? SBST_SELIR : SBST_CAPDR;
      SBST_CAPDR: state_nxt = tms_in ? SBST_EX1DR : SBST_SHDR;
      SBST_SHDR:  state_nxt = tms_in ? SBST_EX1DR : SBST_SHDR;
      SBST_EX1DR: state_nxt = tms_in ? SBST_UPDR  : SBST_PDR;
      SBST_PDR:   state_nxt = tms_in ? SBST_EX2DR : SBST_PDR;
      SBST_EX2DR: state_nxt = tms_in ? SBST_UPDR  : SBST_SHDR;
      SBST_UPDR:  state_nxt = tms_in ? SBST_SELDR : SBST_RTI;
      SBST_SELIR: state_nxt = tms_in ? SBST_TLR   : SBST_CAPIR;
      SBST_CAPIR: state_nxt = tms_in ? SBST_EX1IR : SBST_SHIR;
      SBST_SHIR:  state_nxt = tms_in ? SBST_EX1IR : SBST_SHIR;
      SBST_EX1IR: state_nxt = tms_in ? SBST_UPIR  : SBST_PIR;
      SBST_PIR:   state_nxt = tms_in ? SBST_EX2IR : SBST_PIR;
      SBST_EX2IR: state_nxt = tms_in ? SBST_UPIR  : SBST_SHIR;
      SBST_UPIR:  state_nxt = tms_in ? SBST_SELDR : SBST_RTI;
      default:    state_nxt = SBST_TLR;
    endcase
  end

  // State register; reset lands in test-logic-reset.
  always_ff @(posedge tck_in)
  begin
    if (rst_in)
      state_r <= SBST_TLR;
    else
      state_r <= state_nxt;
  end

  assign state_out = state_r;

endmodule // sbst_tap_fsm

/* File: pkg/sbst_pkg.sv */
// Shared constants, types and decode helpers for the memory test access port.
package sbst_pkg;

  // Scan register lengths.
  localparam int SBST_IR_LEN  = 3;  // Instruction register length.
  localparam int SBST_ID_LEN  = 32; // Identification register length.
  localparam int SBST_BSR_LEN = 72; // Boundary chain length of the wide configuration.

  // Instruction codes.
  localparam logic [2:0] SBST_IR_EXTEST  = 3'h0; // Capture ring, outputs off.
  localparam logic [2:0] SBST_IR_IDCODE  = 3'h1; // Identification path.
  localparam logic [2:0] SBST_IR_SAMPLEZ = 3'h2; // Capture ring, outputs off.
  localparam logic [2:0] SBST_IR_RSVD3   = 3'h3; // Reserved code.
  localparam logic [2:0] SBST_IR_SAMPLE  = 3'h4; // Capture ring, memory untouched.
  localparam logic [2:0] SBST_IR_RSVD5   = 3'h5; // Reserved code.
  localparam logic [2:0] SBST_IR_RSVD6   = 3'h6; // Reserved code.
  localparam logic [2:0] SBST_IR_BYPASS  = 3'h7; // Single-bit bypass path.

  // Fixed pattern loaded into the instruction shifter on capture.
  localparam logic [2:0] SBST_IR_CAPTURE = 3'h1;

  // Identification field positions (least significant bit of each field).
  localparam int SBST_ID_PRESENT_BIT = 0;  // Presence bit, always one.
  localparam int SBST_ID_MAKER_LSB   = 1;  // Bits 11:1, maker code.
  localparam int SBST_ID_DEVICE_LSB  = 12; // Bits 17:12, device identifier.
  localparam int SBST_ID_WIDTH_LSB   = 18; // Bits 22:18, word width.
  localparam int SBST_ID_DEPTH_LSB   = 23; // Bits 27:23, memory depth.
  localparam int SBST_ID_REV_LSB     = 28; // Bits 31:28, revision.

  // Reset values.
  localparam logic       SBST_BYPASS_CAPTURE = 1'h0; // Bypass bit loads zero on capture.
  localparam logic       SBST_OFF_RESET      = 1'h0; // Outputs enabled out of reset.

  // Sixteen controller states, Gray coded along the usual walk.
  typedef enum logic [3:0] {
    SBST_TLR   = 4'h0, SBST_RTI   = 4'h1, SBST_SELDR = 4'h3, SBST_CAPDR = 4'h2,
    SBST_SHDR  = 4'h6, SBST_EX1DR = 4'h7, SBST_PDR   = 4'h5, SBST_EX2DR = 4'h4,
    SBST_UPDR  = 4'hC, SBST_SELIR = 4'hD, SBST_CAPIR = 4'hF, SBST_SHIR  = 4'hE,
    SBST_EX1IR = 4'hA, SBST_PIR   = 4'hB, SBST_EX2IR = 4'h9, SBST_UPIR  = 4'h8
  } sbst_state_e;

  // True when the instruction turns the memory output drivers off.
  function automatic logic sbst_forces_off(input logic [2:0] ir);
    return (ir == SBST_IR_EXTEST) || (ir == SBST_IR_SAMPLEZ);
  endfunction

  // True when the instruction places the boundary chain in the path.
  function automatic logic sbst_uses_bsr(input logic [2:0] ir);
    return (ir == SBST_IR_EXTEST) || (ir == SBST_IR_SAMPLEZ) || (ir == SBST_IR_SAMPLE);
  endfunction

endpackage

/* File: testbench/sbst_ctl_model.sv */
// Behavioural model of the external boundary-scan controller that drives the test port.
`timescale 1ns/1ps
module sbst_ctl_model
(
  output logic      tck_out = 1'b0, // Test clock, held low between frames.
  output logic      tms_out = 1'b1, // Mode select, changed only while the clock is low.
  output logic      tdi_out = 1'b0, // Test data in.
  input  wire logic tdo_in          // Resolved test data out line.
);
  logic ph = 1'b1; // Free-running 30 ns phase reference, unrelated to the memory clock.

  // The reference only paces pulses; the test clock itself moves only inside tasks.
  initial
  begin
    #7;
    forever #15 ph = ~ph;
  end

  // One test clock pulse; data out is taken at the rising edge, as the port expects.
  task automatic pulse(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    @(negedge ph);
    tck_out = 1'b1;
    tdo = tdo_in;
    @(posedge ph);
    tck_out = 1'b0;
  endtask

  // Several pulses at one mode level; data in toggles so that it never looks helpful.
  task automatic clocks(input logic tms, input int n);
    logic d;
    repeat (n) pulse(tms, ~tdi_out, d);
  endtask

  // Walks from idle through capture, shift and update back to idle, shifting n bits.
  task automatic scan(input logic is_ir, input int n, input logic [71:0] din, output logic [71:0] dout);
    logic d;
    dout = '0;
    clocks(1'b1, is_ir ? 2 : 1);
    clocks(1'b0, 2);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], d);
      dout[i] = d;
    end
    clocks(1'b1, 1);
    clocks(1'b0, 1);
  endtask
endmodule // sbst_ctl_model

/* File: testbench/tb_top.sv */
// Self-checking testbench of the memory test access port.
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp); \
    end \
  end
module tb_top
  import sbst_pkg::*;
();
  localparam logic [3:0]  REV   = 4'hA;   // Revision field chosen for the run.
  localparam logic [4:0]  DEP   = 5'h13;  // Depth field chosen for the run.
  localparam logic [4:0]  WID   = 5'h0C;  // Width field chosen for the run.
  localparam logic [5:0]  DEV   = 6'h2D;  // Device field chosen for the run.
  localparam logic [10:0] MAKER = 11'h4B3; // Maker code; value is arbitrary.

  logic        clk = 1'b0;  // Memory-side clock.
  logic        rst = 1'b1;  // Reset, high from time zero.
  logic [71:0] ring = '0;   // Pin levels presented to the ring.
  logic        flt = 1'b0;  // Changing level shown while data out is not driven.
  wire         tck, tms, tdi;
  logic        tdo, tdo_en, outs_off;
  wire         tdo_line = tdo_en ? tdo : flt; // Undriven line shows no stale value.
  int          n_mismatch = 0;
  int          cmp_count = 0;

  sbst_tap #(.ID_REVISION(REV), .ID_DEPTH(DEP), .ID_WIDTH(WID), .ID_DEVICE(DEV), .ID_MAKER(MAKER)) dut (
    .CLK_IN(clk), .RESET_IN(rst), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .RING_IN(ring),
    .TDO_OUT(tdo), .TDO_EN_OUT(tdo_en), .OUTPUTS_OFF_OUT(outs_off));
  sbst_ctl_model ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));

  // Memory clock at 10 MHz and the floating-line pattern.
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) flt <= ~flt;

  // Reset with the test clock running, then park the controller in idle.
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    fork
      ctl.clocks(1'b1, 6);
      // Counted from the first falling edge, this holds reset for three memory clock cycles at the start.
      repeat (3) @(negedge clk);
    join
    rst = 1'b0;
    ctl.clocks(1'b1, 5);
    ctl.clocks(1'b0, 1);
  endtask

  // Lets an instruction change cross into the memory clock domain.
  task automatic settle();
    ctl.clocks(1'b0, 2);
    repeat (4) @(negedge clk);
  endtask

  // Reads 33 bits of the identification path; bit 32 must be the first bit shifted in.
  task automatic id_check();
    logic [71:0] d;
    ctl.scan(1'b0, 33, 72'h1, d);
    `CHK(d[0], 1'b1, "presence bit")
    `CHK(d[32], 1'b1, "path length")
    `CHK(d[11:1], MAKER, "maker code")
    `CHK(d[31:28], REV, "revision")
    `CHK(d[27:18], {DEP, WID}, "depth and width")
    `CHK(d[17:12], DEV, "device field")
    `CHK(outs_off, 1'b0, "outputs on with id")
  endtask

  // After reset the identification path is selected and data out is idle.
  task automatic t_power_up();
    do_reset();
    id_check();
    `CHK(tdo_en, 1'b0, "data out idle")
  endtask

  // Instruction capture pattern, then the one-bit bypass delay.
  task automatic t_bypass();
    logic [71:0] d;
    ctl.scan(1'b1, 3, 72'h7, d);
    `CHK(d[2:0], SBST_IR_CAPTURE, "instruction capture")
    settle();
    ctl.scan(1'b0, 4, 72'hD, d);
    `CHK(d[3:0], 4'hA, "bypass path")
    `CHK(outs_off, 1'b0, "outputs on in bypass")
    ctl.scan(1'b1, 3, {69'h0, SBST_IR_IDCODE}, d);
    settle();
    id_check();
  endtask

  // Boundary instructions: output control, ring capture, update acting as pause.
  task automatic t_boundary();
    logic [2:0]  codes [3] = '{SBST_IR_SAMPLE, SBST_IR_SAMPLEZ, SBST_IR_EXTEST};
    logic [71:0] d;
    logic        off;
    for (int k = 0; k < 3; k++)
    begin
      off = (codes[k] != SBST_IR_SAMPLE);
      @(negedge clk);
      ring = {5'h15, codes[k], 64'h0123_4567_89AB_CDEF} ^ {72{k[0]}};
      ctl.scan(1'b1, 3, {69'h0, codes[k]}, d);
      settle();
      `CHK(outs_off, off, "output control")
      // Shifting in the present level leaves the chain different from the inverted ring captured next.
      // A capture that loads nothing therefore shows up as a mismatch in the second read.
      ctl.scan(1'b0, 72, ring, d);
      `CHK(d, ring, "ring capture")
      @(negedge clk);
      ring = ~ring;
      settle();
      ctl.scan(1'b0, 72, 72'h0, d);
      `CHK(d, ring, "capture after update")
      `CHK(outs_off, off, "output control kept")
    end
  endtask

  // Test-logic-reset by mode select and a mid-run reset both return to identification.
  task automatic t_reselect();
    logic [71:0] d;
    ctl.clocks(1'b1, 5);
    ctl.clocks(1'b0, 1);
    settle();
    `CHK(outs_off, 1'b0, "outputs on after test reset")
    id_check();
    ctl.scan(1'b1, 3, {69'h0, SBST_IR_EXTEST}, d);
    settle();
    `CHK(outs_off, 1'b1, "outputs off again")
    do_reset();
    `CHK(outs_off, 1'b0, "outputs on after reset")
    id_check();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    t_power_up();
    t_bypass();
    t_boundary();
    t_reselect();
    results();
  end

  // Some twenty scans of at most 80 pulses need about 48 us; allow several times that.
  initial
  begin
    #400000;
    n_mismatch++;
    $display("ERROR at %0t: run did not finish", $time);
    results();
  end
endmodule // tb_top
